/* rtl/hss_pkg.sv */
// shared constants and carrier types of the hot-swap startup sequencer
package hss_pkg;
   // ----------------------------------------------------------------
   // time base
   // ----------------------------------------------------------------
   localparam int CLK_MHZ      = 20;       // sys_clk rate in MHz
   localparam int T_EN_DEG_US  = 100;      // enable deglitch, microseconds
   localparam int T_PRS_DEG_US = 400;      // card-present deglitch, microseconds
   localparam int T_SU_US      = 52000;    // startup limit, microseconds (52 ms)
   localparam int T_PG_US      = 16000;    // power-good delay, microseconds (16 ms)
   localparam int T_SHORT_US   = 13200;    // short window, microseconds (13.2 ms)
   localparam int T_RETRY_US   = 3400000;  // retry wait, microseconds (3.4 s)
   localparam int T_OC_US      = 200;      // slow trip budget at unit overdrive
   // derived cycle counts
   localparam int EN_DEG_CYC   = T_EN_DEG_US * CLK_MHZ;
   localparam int PRS_DEG_CYC  = T_PRS_DEG_US * CLK_MHZ;
   localparam int SU_CYC       = T_SU_US * CLK_MHZ;
   localparam int PG_CYC       = T_PG_US * CLK_MHZ;
   localparam int SHORT_CYC    = T_SHORT_US * CLK_MHZ;
   localparam int RETRY_CYC    = T_RETRY_US * CLK_MHZ;
   localparam int OC_CYC       = T_OC_US * CLK_MHZ;
   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int TMR_W        = 27;       // holds the retry count
   localparam int OC_W         = 3;        // overdrive magnitude width
   localparam int ACC_W        = 16;       // slow trip accumulator width
   // ----------------------------------------------------------------
   // comparator flags carried as one packed word
   // ----------------------------------------------------------------
   typedef struct packed {
      logic supply_lockout;   // control supply below lockout level
      logic uv_ok;            // window sense above undervoltage level
      logic ov;               // window sense above overvoltage level
      logic over_temp;        // junction over temperature
      logic out_above_90;     // output above 90 percent of input
      logic gate_ov_3v;       // gate overdrive above 3 V
      logic out_below_1v;     // output below 1 V
      logic oc_fast;          // fast short-circuit comparator
   } hss_flags_t;
   // ----------------------------------------------------------------
   // sequencer states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_OFF    = 6'h01,
      ST_CHECK  = 6'h02,
      ST_START  = 6'h04,
      ST_NORMAL = 6'h08,
      ST_RETRY  = 6'h10,
      ST_LATCH  = 6'h20
   } hss_state_t;
endpackage

/* rtl/hss_deglitch.sv */
// pin synchroniser with a hold-time qualifier
`timescale 1ns/100ps
`default_nettype none
module hss_deglitch #(
   parameter int   CNT = 2000,   // cycles the level must hold
   parameter logic POL = 1'b1    // level that is being qualified
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // pin side
   input  wire logic pin,
   // qualified outputs
   output logic      level_s,    // synchronised pin level
   output logic      held_q      // level POL held for more than CNT cycles
);
   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   if (CNT < 1) begin : g_bad
      $error("hss_deglitch: CNT must be at least one");
   end
   localparam int W = $clog2(CNT + 2);
   logic         meta_q;        // first stage, read only by second
   logic [W-1:0] cnt_q;         // time the level has been held
   // two flip-flop synchroniser
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         // reset to the level that does not qualify, so no false hold follows reset
         meta_q  <= ~POL;
         level_s <= ~POL;
      end else begin
         meta_q  <= pin;
         level_s <= meta_q;
      end
   end
   // hold counter, restarts on any glitch back
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt_q  <= '0;
         held_q <= 1'b0;
      end else if (level_s != POL) begin
         cnt_q  <= '0;
         held_q <= 1'b0;
      end else begin
         if (cnt_q <= W'(CNT)) begin
            cnt_q <= cnt_q + W'(1);
         end
         held_q <= (cnt_q >= W'(CNT));
      end
   end
endmodule
`default_nettype wire

/* rtl/hss_sequencer.sv */
// control sequencer of the integrated hot-swap switch
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [R1] enable held high over 100 us before turn-on
// [R2] card present held low over 400 us
// [R3] turn-on needs supply ok and window ok
// [R4] window or lockout fault forces switch off
// [R5] startup limit timer of 52 ms
// [R6] output high and gate overdrive end startup
// [R7] power-good released 16 ms after startup
// [R8] output below 1 V at 13.2 ms trips
// [R9] over temperature turns switch off always
// [R10] overcurrent protection only in normal operation
// [R11] faults latch off or retry by option
// [R12] enable low disables switch at once
// [R13] power-good low until switch fully enhanced
// [R14] foldback limiting only during startup
// [R15] bigger overcurrent trips sooner
// [R16] retry restarts after 3.4 s wait
// [R17] latch cleared by enable low or supply events
// [R18] output already high blocks turn-on as fault
// [R19] flags synchronised, delays counted in cycles
module hss_sequencer #(
   parameter int   SU_CNT     = hss_pkg::SU_CYC,
   parameter int   PG_CNT     = hss_pkg::PG_CYC,
   parameter int   SHORT_CNT  = hss_pkg::SHORT_CYC,
   parameter int   RETRY_CNT  = hss_pkg::RETRY_CYC,
   parameter int   PRS_CNT    = hss_pkg::PRS_DEG_CYC,
   parameter int   EN_CNT     = hss_pkg::EN_DEG_CYC,
   parameter int   OC_CNT     = hss_pkg::OC_CYC,
   parameter logic AUTO_RETRY = 1'b0     // 1: retry variant, 0: latch-off
) (
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   // host pins
   input  wire logic               enable,
   input  wire logic               card_present_n,
   // comparator flags, asynchronous
   input  wire hss_pkg::hss_flags_t flags,
   input  wire logic [2:0]         oc_level,       // overdrive magnitude, 0 none
   // switch control
   output logic                    switch_on_q,
   output logic                    foldback_q,
   output logic                    gate_discharge_q,
   // open-drain power-good pin
   output logic                    power_good_out_q,
   output logic                    power_good_oe_q,
   // status
   output logic                    fault_latched_q
);
   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (SU_CNT < 2 || PG_CNT < 2 || SHORT_CNT < 2 || SHORT_CNT >= SU_CNT ||
       RETRY_CNT < 2 || RETRY_CNT >= (1 << hss_pkg::TMR_W) || OC_CNT < 1 ||
       OC_CNT >= (1 << (hss_pkg::ACC_W - 1))) begin : g_bad
      $error("hss_sequencer: count parameter out of range");
   end
   localparam int TW = hss_pkg::TMR_W;
   localparam int AW = hss_pkg::ACC_W;
   // ----------------------------------------------------------------
   // input qualification
   // ----------------------------------------------------------------
   logic en_s;         // synchronised enable level
   logic en_ok;        // enable held high long enough
   logic en_off_ok;    // enable held low long enough
   logic prs_s;        // synchronised card-present level
   logic prs_ok;       // card held present long enough
   // enable high qualifier
   hss_deglitch #(.CNT(EN_CNT), .POL(1'b1)) u_en_hi ( // R1
      .sys_clk (sys_clk), .rst_n (rst_n), .pin (enable),
      .level_s (en_s), .held_q (en_ok));
   // enable low qualifier used to clear the latch
   hss_deglitch #(.CNT(EN_CNT), .POL(1'b0)) u_en_lo ( // R17
      .sys_clk (sys_clk), .rst_n (rst_n), .pin (enable),
      .level_s (), .held_q (en_off_ok));
   // card-present low qualifier
   hss_deglitch #(.CNT(PRS_CNT), .POL(1'b0)) u_prs ( // R2
      .sys_clk (sys_clk), .rst_n (rst_n), .pin (card_present_n),
      .level_s (prs_s), .held_q (prs_ok));
   // comparator flags through two flip-flops
   hss_pkg::hss_flags_t flg_m_q;   // first stage
   hss_pkg::hss_flags_t flg_s;     // synchronised flags
   logic [2:0]          ocl_m_q;   // first stage
   logic [2:0]          ocl_s;     // synchronised magnitude
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         flg_m_q <= '0;
         flg_s   <= '0;
         ocl_m_q <= 3'h0;
         ocl_s   <= 3'h0;
      end else begin
         flg_m_q <= flags; // R19
         flg_s   <= flg_m_q;
         ocl_m_q <= oc_level;
         ocl_s   <= ocl_m_q;
      end
   end
   // supply window and lockout good
   logic win_ok;
   logic qual;
   assign win_ok = !flg_s.supply_lockout && flg_s.uv_ok && !flg_s.ov; // R3
   assign qual   = win_ok && en_ok && prs_ok && !flg_s.over_temp;
   // ----------------------------------------------------------------
   // overcurrent detection, normal operation only
   // ----------------------------------------------------------------
   logic [AW-1:0] acc_q;    // overdrive integrated over time
   logic          oc_trip;  // slow or fast trip
   hss_pkg::hss_state_t state_q, state_d;
   // larger magnitude adds faster, so it reaches the budget sooner
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         acc_q <= '0;
      end else if (state_q != hss_pkg::ST_NORMAL || ocl_s == 3'h0) begin
         acc_q <= '0;
      end else if (acc_q < AW'(OC_CNT)) begin
         acc_q <= acc_q + AW'(ocl_s); // R15
      end
   end
   assign oc_trip = (state_q == hss_pkg::ST_NORMAL) &&
                    (flg_s.oc_fast || acc_q >= AW'(OC_CNT)); // R10
   // ----------------------------------------------------------------
   // state machine
   // ----------------------------------------------------------------
   logic [TW-1:0] timer_q;    // time in current state
   hss_pkg::hss_state_t fault_st;
   assign fault_st = AUTO_RETRY ? hss_pkg::ST_RETRY : hss_pkg::ST_LATCH; // R11
   // next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         // wait for every enable condition
         hss_pkg::ST_OFF: begin
            if (qual) begin
               state_d = hss_pkg::ST_CHECK;
            end
         end
         // input-to-output short check before turn-on
         hss_pkg::ST_CHECK: begin
            if (flg_s.out_above_90) begin
               state_d = fault_st; // R18
            end else begin
               state_d = hss_pkg::ST_START;
            end
         end
         // timed inrush phase
         hss_pkg::ST_START: begin
            if (flg_s.out_above_90 && flg_s.gate_ov_3v) begin
               state_d = hss_pkg::ST_NORMAL; // R6
            end else if (timer_q == TW'(SHORT_CNT - 1) && flg_s.out_below_1v) begin
               state_d = fault_st; // R8
            end else if (timer_q == TW'(SU_CNT - 1)) begin
               state_d = fault_st; // R5
            end
         end
         // running, watch for overcurrent
         hss_pkg::ST_NORMAL: begin
            if (oc_trip) begin
               state_d = fault_st;
            end
         end
         // wait, then restart
         hss_pkg::ST_RETRY: begin
            if (timer_q == TW'(RETRY_CNT - 1)) begin
               state_d = hss_pkg::ST_OFF; // R16
            end
         end
         // latched off until cleared
         hss_pkg::ST_LATCH: begin
            if (en_off_ok || !win_ok || prs_s) begin
               state_d = hss_pkg::ST_OFF; // R17
            end
         end
         default: state_d = hss_pkg::ST_OFF;
      endcase
      // global turn-off, except that a latch ignores short enable drops and over temperature
      if (state_q != hss_pkg::ST_LATCH &&
          (!win_ok || !en_s || flg_s.over_temp)) begin
         state_d = hss_pkg::ST_OFF; // R4 R9 R12
      end
   end
   // state register and shared timer, cleared on each change
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q <= hss_pkg::ST_OFF;
         timer_q <= '0;
      end else begin
         state_q <= state_d;
         if (state_d != state_q) begin
            timer_q <= '0;
         end else if (timer_q != {TW{1'b1}}) begin
            timer_q <= timer_q + TW'(1);
         end
      end
   end
   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   logic on_d;
   assign on_d = (state_d == hss_pkg::ST_START) || (state_d == hss_pkg::ST_NORMAL);
   // switch, foldback and discharge drive
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         switch_on_q      <= 1'b0;
         foldback_q       <= 1'b0;
         gate_discharge_q <= 1'b0;
         fault_latched_q  <= 1'b0;
      end else begin
         switch_on_q      <= on_d;
         foldback_q       <= (state_d == hss_pkg::ST_START); // R14
         gate_discharge_q <= oc_trip;
         fault_latched_q  <= (state_d == hss_pkg::ST_LATCH);
      end
   end
   // power-good pulls low unless normal for the full delay
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         power_good_out_q <= 1'b0;
         power_good_oe_q  <= 1'b1;
      end else begin
         power_good_out_q <= 1'b0;
         power_good_oe_q  <= !(state_d == hss_pkg::ST_NORMAL && state_q == state_d &&
                               timer_q >= TW'(PG_CNT - 1)); // R7 R13
      end
   end
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_check_entry;
      state_q == hss_pkg::ST_OFF && qual ##1 state_q == hss_pkg::ST_CHECK;
   endsequence
   property p_check_order;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(switch_on_q) |-> $past(state_q, 2) == hss_pkg::ST_OFF;
   endproperty
   a_check_order: assert property (p_check_order) // R18
      else $error("switch turned on without short check");
   property p_en_qual;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(switch_on_q) |-> $past(en_ok, 2);
   endproperty
   a_en_qual: assert property (p_en_qual) // R1
      else $error("switch on without qualified enable");
   property p_prs_qual;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(switch_on_q) |-> $past(prs_ok, 2) && $past(win_ok, 2);
   endproperty
   a_prs_qual: assert property (p_prs_qual) // R2
      else $error("switch on without card present or window");
   property p_en_off;
      @(posedge sys_clk) disable iff (!rst_n)
      !en_s |=> !switch_on_q;
   endproperty
   a_en_off: assert property (p_en_off) // R12
      else $error("switch stayed on with enable low");
   property p_win_off;
      @(posedge sys_clk) disable iff (!rst_n)
      !win_ok |=> !switch_on_q && !foldback_q;
   endproperty
   a_win_off: assert property (p_win_off) // R4
      else $error("switch stayed on with supply fault");
   property p_ot_off;
      @(posedge sys_clk) disable iff (!rst_n)
      flg_s.over_temp |=> !switch_on_q;
   endproperty
   a_ot_off: assert property (p_ot_off) // R9
      else $error("switch stayed on in over temperature");
   property p_fold;
      @(posedge sys_clk) disable iff (!rst_n)
      foldback_q |-> switch_on_q && power_good_oe_q;
   endproperty
   a_fold: assert property (p_fold) // R14
      else $error("foldback outside startup");
   property p_pg_rel;
      @(posedge sys_clk) disable iff (!rst_n)
      $fell(power_good_oe_q) |-> switch_on_q && $past(timer_q) == TW'(PG_CNT - 1);
   endproperty
   a_pg_rel: assert property (p_pg_rel) // R7
      else $error("power-good released at wrong time");
   property p_su_lim;
      @(posedge sys_clk) disable iff (!rst_n)
      state_q == hss_pkg::ST_START |-> timer_q < TW'(SU_CNT);
   endproperty
   a_su_lim: assert property (p_su_lim) // R5
      else $error("startup exceeded its limit");
   property p_oc_norm;
      @(posedge sys_clk) disable iff (!rst_n)
      gate_discharge_q |-> $past(state_q) == hss_pkg::ST_NORMAL ##1 !switch_on_q;
   endproperty
   a_oc_norm: assert property (p_oc_norm) // R10
      else $error("overcurrent trip outside normal operation");
   property p_entry;
      @(posedge sys_clk) disable iff (!rst_n)
      s_check_entry |=> state_q != hss_pkg::ST_CHECK;
   endproperty
   a_entry: assert property (p_entry) // R18
      else $error("short check lasted more than one cycle");
endmodule
`default_nettype wire

/* tb/hss_host_model.sv */
// host side model: enable and card-present drivers, pulled-up power-good wire
`timescale 1ns/100ps
`default_nettype none
module hss_host_model (
   // clock
   input  wire logic sys_clk,
   // requests from the bench
   input  wire logic want_en,
   input  wire logic want_card,
   // open-drain power-good pin of the device
   input  wire logic pg_out,
   input  wire logic pg_oe,
   // host lines
   output var logic  enable,
   output var logic  card_present_n,
   output wire logic pg_wire
);
   // host moves its lines just after a clock edge; idle requests during reset
   always @(posedge sys_clk) begin
      enable         <= want_en;
      card_present_n <= ~want_card;
   end
   // board pull-up wins whenever the device lets go of the pin
   assign pg_wire = pg_oe ? pg_out : 1'b1;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench of the hot-swap startup sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   // ----------------------------------------------------------------
   // short counts and signals
   // ----------------------------------------------------------------
   localparam int EN  = 4;    // enable qualifier
   localparam int PRS = 8;    // card qualifier
   localparam int SU  = 200;  // startup limit
   localparam int SH  = 50;   // short window
   localparam int PG  = 30;   // power-good delay
   localparam int OC  = 20;   // slow trip budget
   localparam hss_pkg::hss_flags_t SAFE = hss_pkg::hss_flags_t'(8'h40);  // window ok only
   logic                sys_clk, rst_n, want_en, want_card;
   logic                enable, card_present_n, pg_wire;
   hss_pkg::hss_flags_t flags;
   logic [2:0]          oc_level;
   logic                sw, fb, gd, pg_out, pg_oe, flt;
   int                  n_mismatch, checks, n;
   // ----------------------------------------------------------------
   // design and host
   // ----------------------------------------------------------------
   hss_sequencer #(.SU_CNT(SU), .PG_CNT(PG), .SHORT_CNT(SH), .RETRY_CNT(100),
      .PRS_CNT(PRS), .EN_CNT(EN), .OC_CNT(OC), .AUTO_RETRY(1'b0)) hss_sequencer_i (
      .sys_clk(sys_clk), .rst_n(rst_n), .enable(enable), .card_present_n(card_present_n),
      .flags(flags), .oc_level(oc_level), .switch_on_q(sw), .foldback_q(fb),
      .gate_discharge_q(gd), .power_good_out_q(pg_out), .power_good_oe_q(pg_oe),
      .fault_latched_q(flt));
   hss_host_model hss_host_model_i (.sys_clk(sys_clk), .want_en(want_en),
      .want_card(want_card), .pg_out(pg_out), .pg_oe(pg_oe), .enable(enable),
      .card_present_n(card_present_n), .pg_wire(pg_wire));
   // 50 ns clock
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // step k edges, then sample once outputs settled
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   // single-bit result
   task automatic chk_bit(input logic got, input logic exp, input string m);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   // cycle count result
   task automatic chk_rng(input int got, input int lo, input int hi, input string m);
      checks++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("BAD %0t %s got %0d", $time, m, got);
      end
   endtask
   // output picked by number
   function automatic logic pick(input int s);
      case (s)
         0: return sw;
         1: return fb;
         2: return pg_oe;
         default: return gd;
      endcase
   endfunction
   // bounded wait for an output level, k counts edges
   task automatic wait_on(input int s, input logic v, input int lim, output int k);
      k = 0;
      while (pick(s) !== v && k < lim) begin
         cyc(1);
         k++;
      end
   endtask
   // count cycles in which an output is high
   task automatic watch(input int s, input int len, output int hits);
      hits = 0;
      repeat (len) begin
         cyc(1);
         if (pick(s) !== 1'b0) hits++;
      end
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // plain startup up to power good
   task automatic t_startup;
      chk_bit(sw, 1'b0, "switch on after reset");
      chk_bit(pg_wire, 1'b0, "pg not low after reset");
      @(posedge sys_clk) want_card <= 1'b1;
      cyc(PRS + 12);
      chk_bit(sw, 1'b0, "on without enable");
      @(posedge sys_clk) want_en <= 1'b1;
      wait_on(0, 1'b1, 40, n);
      chk_rng(n, EN + 1, EN + 8, "enable qualify time");
      chk_bit(fb, 1'b1, "no foldback in startup");
      @(posedge sys_clk) flags.out_above_90 <= 1'b1;
      cyc(10);
      chk_bit(fb, 1'b1, "startup left on one flag");
      @(posedge sys_clk) flags.gate_ov_3v <= 1'b1;
      wait_on(1, 1'b0, 10, n);
      chk_rng(n, 1, 5, "startup exit time");
      chk_bit(pg_oe, 1'b1, "pg released early");
      wait_on(2, 1'b0, 60, n);
      chk_rng(n, PG - 2, PG + 2, "pg delay");
      chk_bit(pg_wire, 1'b1, "pg wire not released");
   endtask
   // fast trip in normal, latch-off and its clearing
   task automatic t_fast_oc;
      @(posedge sys_clk) flags.oc_fast <= 1'b1;
      wait_on(3, 1'b1, 8, n);
      chk_rng(n, 1, 5, "fast trip time");
      chk_bit(sw, 1'b0, "switch on at trip");
      cyc(1);
      chk_bit(flt, 1'b1, "no latch-off");
      chk_bit(pg_wire, 1'b0, "pg high after fault");
      @(posedge sys_clk) flags <= SAFE;
      @(posedge sys_clk) want_en <= 1'b0;
      @(posedge sys_clk) want_en <= 1'b1;
      cyc(12);
      chk_bit(flt, 1'b1, "short enable drop cleared latch");
      chk_bit(sw, 1'b0, "latched switch came on");
      @(posedge sys_clk) want_en <= 1'b0;
      cyc(EN + 8);
      chk_bit(flt, 1'b0, "long enable drop kept latch");
   endtask
   // card qualifier with enable already high
   task automatic t_card;
      @(posedge sys_clk) want_card <= 1'b0;
      @(posedge sys_clk) want_en <= 1'b1;
      cyc(12);
      chk_bit(sw, 1'b0, "on without card");
      @(posedge sys_clk) want_card <= 1'b1;
      wait_on(0, 1'b1, 40, n);
      chk_rng(n, PRS + 1, PRS + 8, "card qualify time");
   endtask
   // each off cause: temperature, overvoltage, undervoltage, lockout
   task automatic t_offs;
      for (int c = 0; c < 4; c++) begin
         @(posedge sys_clk) flags <= hss_pkg::hss_flags_t'(8'h40 ^ (8'h10 << c));
         wait_on(0, 1'b0, 8, n);
         chk_rng(n, 1, 5, "off cause response");
         chk_bit(fb, 1'b0, "foldback outside startup");
         cyc(20);
         chk_bit(sw, 1'b0, "on while blocked");
         @(posedge sys_clk) flags <= SAFE;
         wait_on(0, 1'b1, 30, n);
         chk_rng(n, 1, 29, "no restart");
      end
      @(posedge sys_clk) want_en <= 1'b0;
      wait_on(0, 1'b0, 8, n);
      chk_rng(n, 1, 5, "enable low response");
   endtask
   // startup limit expiry, overcurrent ignored meanwhile
   task automatic t_limit;
      @(posedge sys_clk) want_en <= 1'b1;
      wait_on(0, 1'b1, 20, n);
      @(posedge sys_clk) flags.oc_fast <= 1'b1;
      watch(3, SU - 10, n);
      chk_rng(n, 0, 0, "trip during startup");
      wait_on(0, 1'b0, 20, n);
      chk_rng(n, 5, 14, "startup limit");
      cyc(1);
      chk_bit(flt, 1'b1, "limit not latched");
      @(posedge sys_clk) flags <= hss_pkg::hss_flags_t'(8'h02);
      wait_on(0, 1'b0, 1, n);
      cyc(6);
      chk_bit(flt, 1'b0, "undervoltage kept latch");
   endtask
   // output held below 1 V, then card pulled
   task automatic t_short;
      @(posedge sys_clk) flags.uv_ok <= 1'b1;
      wait_on(0, 1'b1, 20, n);
      wait_on(0, 1'b0, SH + 10, n);
      chk_rng(n, SH - 3, SH + 2, "short window");
      cyc(1);
      chk_bit(flt, 1'b1, "short not latched");
      @(posedge sys_clk) want_card <= 1'b0;
      cyc(8);
      chk_bit(flt, 1'b0, "card removal kept latch");
   endtask
   // output already high at check blocks turn-on
   task automatic t_in_short;
      @(posedge sys_clk) flags <= hss_pkg::hss_flags_t'(8'h48);
      @(posedge sys_clk) want_card <= 1'b1;
      watch(0, PRS + 20, n);
      chk_rng(n, 0, 0, "turn-on into shorted output");
      chk_bit(flt, 1'b1, "shorted output not a fault");
   endtask
   // clear the latch by a supply event, start into normal, trip on slow overdrive
   task automatic slow_trip(input logic [2:0] lv, input hss_pkg::hss_flags_t clr,
                            output int k);
      @(posedge sys_clk) flags <= clr;
      cyc(4);
      chk_bit(flt, 1'b0, "supply event kept latch");
      @(posedge sys_clk) flags <= SAFE;
      wait_on(0, 1'b1, 20, k);
      @(posedge sys_clk) flags <= hss_pkg::hss_flags_t'(8'h4C);
      wait_on(1, 1'b0, 10, k);
      @(posedge sys_clk) oc_level <= lv;
      wait_on(3, 1'b1, 40, k);
      chk_bit(flt, 1'b1, "slow trip not latched");
      @(posedge sys_clk) oc_level <= 3'h0;
   endtask
   // slow trip: larger overdrive trips sooner; undervoltage and lockout clear latch
   task automatic t_slow_oc;
      int k1, k7;
      slow_trip(3'h1, hss_pkg::hss_flags_t'(8'h00), k1);
      chk_rng(k1, OC + 2, OC + 6, "unit overdrive trip time");
      slow_trip(3'h7, hss_pkg::hss_flags_t'(8'hC0), k7);
      chk_rng(k7, 3, OC / 7 + 6, "full overdrive trip time");
      chk_rng(k1 - k7, 1, OC, "larger overdrive not sooner");
   endtask
   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task automatic complete_run;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      rst_n = 1'b0;
      want_en = 1'b0;
      want_card = 1'b0;
      flags = SAFE;
      oc_level = 3'h0;
      n_mismatch = 0;
      checks = 0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      cyc(2);
      t_startup;
      t_fast_oc;
      t_card;
      t_offs;
      t_limit;
      t_short;
      t_in_short;
      t_slow_oc;
      complete_run;
   end
   // watchdog well past the expected run
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      complete_run;
   end
endmodule
`default_nettype wire
